// File: core_ptr_defines.svh
// constants for the core pointer and bit addressing block
`ifndef CORE_PTR_DEFINES_SVH
`define CORE_PTR_DEFINES_SVH

`define SFR_STACK_ADDR    8'h81
`define SFR_PZL_ADDR      8'h82
`define SFR_PZH_ADDR      8'h83
`define SFR_POL_ADDR      8'h84
`define SFR_POH_ADDR      8'h85
`define SFR_SEL_ADDR      8'h92
`define SFR_CTL_ADDR      8'h93
`define SFR_B_ADDR        8'hF0
`define SFR_BASE          8'h80
`define BIT_RAM_BASE      8'h20
`define STACK_RESET       8'h07
`define SEL_RESET         8'h00
`define CTL_RESET         4'h0
`define CTL_EN_BIT        0
`define CTL_DIR_BIT       1
`define CTL_STEP_BIT      2
`define CTL_NEXT_BIT      3

`endif

// File: core_ptr_pkg.sv
// types for the core pointer and bit addressing block
`default_nettype none
package core_ptr_pkg;
	typedef enum logic [1:0]
	{
		STACK_NONE = 2'h0,
		STACK_PUSH = 2'h1,
		STACK_POP  = 2'h3
	} stack_op_e;

	typedef enum logic [1:0]
	{
		MOVE_IDLE = 2'h0,
		MOVE_BUSY = 2'h1
	} move_state_e;
endpackage
`default_nettype wire

// File: bit_addr_decode.sv
// bit address decoder for ram and register bit spaces
`timescale 1ns/1ps
`default_nettype none
`include "core_ptr_defines.svh"

module bit_addr_decode
(
	// bit address in
	input  wire logic [7:0] bit_addr,
	// decoded byte and bit
	output logic      [7:0] byte_addr,
	output logic      [2:0] bit_index,
	output logic            is_sfr
);
	// low half maps onto ram 20h..2fh, upper half onto x0h/x8h registers
	always_comb
	begin
		bit_index = bit_addr[2:0];
		is_sfr    = bit_addr[7];
		if (bit_addr[7])
			byte_addr = {bit_addr[7:3], 3'h0};
		else
			byte_addr = `BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
	end
endmodule
`default_nettype wire

// File: core_ptr_regs.sv
// stack pointer, dual data pointers, b register and bit decode
`timescale 1ns/1ps
`default_nettype none
`include "core_ptr_defines.svh"

// Contract
// - bit 00h-7fh maps to ram 20h-2fh
// - sfr bit addressable only at x0/x8
// - sfr space 80h-ffh direct only
// - stack pointer is eight bits
// - stack pointer resets to 07h
// - push and call pre-increment
// - pop and return post-decrement
// - two 16-bit pointers, byte or word
// - select bit picks active pointer
// - select bits 7-1 read zero
// - next-pointer bit copied after move (here after a data move only, not a code table read)
// - auto modify by one or two
// - each pointer owns its control
// - control address reaches selected copy
// - b register general and mul/div
module core_ptr_regs
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port from core
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic        sfr_direct,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,
	// stack operations
	input  wire core_ptr_pkg::stack_op_e stack_op,
	output logic      [7:0]  stack_addr,
	// pointer moves
	input  wire logic        external_data_move,
	input  wire logic        code_table_read,
	output logic      [15:0] move_addr,
	// multiply and divide
	input  wire logic        muldiv_wr,
	input  wire logic [7:0]  muldiv_b,
	output logic      [7:0]  b_value,
	// bit address decode
	input  wire logic [7:0]  bit_addr,
	output logic      [7:0]  bit_byte_addr,
	output logic      [2:0]  bit_index,
	output logic             bit_is_sfr
);
	logic [7:0]  stack_pointer_reg, stack_pointer_next;
	logic [15:0] data_ptr_zero_reg, data_ptr_zero_next;
	logic [15:0] data_ptr_one_reg, data_ptr_one_next;
	logic        active_ptr_sel_reg, active_ptr_sel_next;
	logic [3:0]  ctl_zero_reg, ctl_zero_next;
	logic [3:0]  ctl_one_reg, ctl_one_next;
	logic [7:0]  b_reg, b_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic        hit_reg, hit_next;
	logic [7:0]  stack_addr_reg, stack_addr_next;
	logic [15:0] move_addr_reg, move_addr_next;
	logic [7:0]  byte_comb;
	logic [2:0]  idx_comb;
	logic        sfr_comb;
	logic [7:0]  byte_reg;
	logic [2:0]  idx_reg;
	logic        sfrb_reg;
	logic        wr_ok;
	logic [3:0]  ctl_act;

	// one pointer modify step
	function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic [3:0] c);
		logic [15:0] d;
		d = c[`CTL_STEP_BIT] ? 16'h0002 : 16'h0001;
		if (!c[`CTL_EN_BIT])
			return p;
		return c[`CTL_DIR_BIT] ? (p - d) : (p + d);
	endfunction

	bit_addr_decode u_bit_dec
	(
		.bit_addr  (bit_addr),
		.byte_addr (byte_comb),
		.bit_index (idx_comb),
		.is_sfr    (sfr_comb)
	);

	// only direct accesses in 80h..ffh reach registers
	assign wr_ok   = sfr_wr && sfr_direct && sfr_addr >= `SFR_BASE;
	assign ctl_act = active_ptr_sel_reg ? ctl_one_reg : ctl_zero_reg;

	// next state of stack, pointer, select, control and b registers; a pointer move wins over a write
	always_comb
	begin
		stack_pointer_next  = stack_pointer_reg;
		data_ptr_zero_next  = data_ptr_zero_reg;
		data_ptr_one_next   = data_ptr_one_reg;
		active_ptr_sel_next = active_ptr_sel_reg;
		ctl_zero_next       = ctl_zero_reg;
		ctl_one_next        = ctl_one_reg;
		b_next              = b_reg;
		stack_addr_next     = stack_addr_reg;
		if (wr_ok)
		begin
			unique case (sfr_addr)
				`SFR_STACK_ADDR: stack_pointer_next = sfr_wdata;
				`SFR_PZL_ADDR: data_ptr_zero_next[7:0] = sfr_wdata;
				`SFR_PZH_ADDR: data_ptr_zero_next[15:8] = sfr_wdata;
				`SFR_POL_ADDR: data_ptr_one_next[7:0] = sfr_wdata;
				`SFR_POH_ADDR: data_ptr_one_next[15:8] = sfr_wdata;
				`SFR_SEL_ADDR: active_ptr_sel_next = sfr_wdata[0];
				`SFR_CTL_ADDR:
				begin
					if (active_ptr_sel_reg)
						ctl_one_next = sfr_wdata[3:0];
					else
						ctl_zero_next = sfr_wdata[3:0];
				end
				`SFR_B_ADDR:   b_next = sfr_wdata;
				default: ;
			endcase
		end
		if (muldiv_wr)
			b_next = muldiv_b;
		// push writes at incremented address; pop reads then decrements
		unique case (stack_op)
			core_ptr_pkg::STACK_PUSH:
			begin
				stack_pointer_next = stack_pointer_reg + 8'h01;
				stack_addr_next    = stack_pointer_reg + 8'h01;
			end
			core_ptr_pkg::STACK_POP:
			begin
				stack_addr_next    = stack_pointer_reg;
				stack_pointer_next = stack_pointer_reg - 8'h01;
			end
			default: ;
		endcase
		if (external_data_move)
		begin
			if (active_ptr_sel_reg)
				data_ptr_one_next = ptr_step(data_ptr_one_reg, ctl_one_reg);
			else
				data_ptr_zero_next = ptr_step(data_ptr_zero_reg, ctl_zero_reg);
			active_ptr_sel_next = ctl_act[`CTL_NEXT_BIT];
		end
	end

	// read data and outward addresses
	always_comb
	begin
		rdata_next = 8'h00;
		hit_next   = 1'b1;
		unique case (sfr_addr)
			`SFR_STACK_ADDR: rdata_next = stack_pointer_reg;
			`SFR_PZL_ADDR: rdata_next = data_ptr_zero_reg[7:0];
			`SFR_PZH_ADDR: rdata_next = data_ptr_zero_reg[15:8];
			`SFR_POL_ADDR: rdata_next = data_ptr_one_reg[7:0];
			`SFR_POH_ADDR: rdata_next = data_ptr_one_reg[15:8];
			`SFR_SEL_ADDR: rdata_next = {7'h00, active_ptr_sel_reg};
			`SFR_CTL_ADDR: rdata_next = {4'h0, ctl_act};
			`SFR_B_ADDR:   rdata_next = b_reg;
			default:       hit_next = 1'b0;
		endcase
		if (!(sfr_rd && sfr_direct && sfr_addr >= `SFR_BASE))
		begin
			rdata_next = 8'h00;
			hit_next   = 1'b0;
		end
		move_addr_next = move_addr_reg;
		if (external_data_move || code_table_read)
			move_addr_next = active_ptr_sel_reg ? data_ptr_one_reg : data_ptr_zero_reg;
	end

	// register stage; async reset takes constants only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			stack_pointer_reg  <= `STACK_RESET;
			data_ptr_zero_reg  <= 16'h0000;
			data_ptr_one_reg   <= 16'h0000;
			active_ptr_sel_reg <= 1'b0;
			ctl_zero_reg       <= `CTL_RESET;
			ctl_one_reg        <= `CTL_RESET;
			b_reg              <= 8'h00;
			rdata_reg          <= 8'h00;
			hit_reg            <= 1'b0;
			stack_addr_reg     <= 8'h00;
			move_addr_reg      <= 16'h0000;
			byte_reg           <= 8'h00;
			idx_reg            <= 3'h0;
			sfrb_reg           <= 1'b0;
		end
		else
		begin
			stack_pointer_reg  <= stack_pointer_next;
			data_ptr_zero_reg  <= data_ptr_zero_next;
			data_ptr_one_reg   <= data_ptr_one_next;
			active_ptr_sel_reg <= active_ptr_sel_next;
			ctl_zero_reg       <= ctl_zero_next;
			ctl_one_reg        <= ctl_one_next;
			b_reg              <= b_next;
			rdata_reg          <= rdata_next;
			hit_reg            <= hit_next;
			stack_addr_reg     <= stack_addr_next;
			move_addr_reg      <= move_addr_next;
			byte_reg           <= byte_comb;
			idx_reg            <= idx_comb;
			sfrb_reg           <= sfr_comb;
		end
	end

	// outputs straight from flops
	assign sfr_rdata     = rdata_reg;
	assign sfr_hit       = hit_reg;
	assign stack_addr    = stack_addr_reg;
	assign move_addr     = move_addr_reg;
	assign b_value       = b_reg;
	assign bit_byte_addr = byte_reg;
	assign bit_index     = idx_reg;
	assign bit_is_sfr    = sfrb_reg;

	// push pre-increments pointer
	push_incr_a: assert property (@(posedge ref_clk) disable iff (rst)
		stack_op == core_ptr_pkg::STACK_PUSH && !wr_ok |=>
		stack_pointer_reg == $past(stack_pointer_reg) + 8'h01 &&
		stack_addr_reg == stack_pointer_reg)
		else $error("push did not pre-increment");

	// pop reads old top then decrements
	pop_decr_a: assert property (@(posedge ref_clk) disable iff (rst)
		stack_op == core_ptr_pkg::STACK_POP && !wr_ok |=>
		stack_addr_reg == stack_pointer_reg + 8'h01)
		else $error("pop did not post-decrement");

	// move address follows select bit
	move_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		code_table_read && !external_data_move |=>
		move_addr_reg == ($past(active_ptr_sel_reg) ? $past(data_ptr_one_reg)
		                                            : $past(data_ptr_zero_reg)))
		else $error("wrong pointer used");

	// auto switch after move
	auto_switch_a: assert property (@(posedge ref_clk) disable iff (rst)
		external_data_move |=> active_ptr_sel_reg == $past(ctl_act[`CTL_NEXT_BIT]))
		else $error("auto switch failed");

	// auto step amount
	auto_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		external_data_move && !active_ptr_sel_reg && ctl_zero_reg == 4'h1 |=>
		data_ptr_zero_reg == $past(data_ptr_zero_reg) + 16'h0001)
		else $error("pointer step wrong");

	// select reads zero above bit 0
	sel_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		sfr_rd && sfr_direct && sfr_addr == `SFR_SEL_ADDR |=>
		sfr_rdata[7:1] == 7'h00 && sfr_hit)
		else $error("select upper bits nonzero");

	// control read shows active copy
	ctl_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		sfr_rd && sfr_direct && sfr_addr == `SFR_CTL_ADDR |=>
		sfr_rdata == {4'h0, $past(active_ptr_sel_reg) ? $past(ctl_one_reg)
		                                              : $past(ctl_zero_reg)})
		else $error("control read wrong copy");

	// indirect access never hits registers
	indirect_miss_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sfr_direct |=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("indirect access hit register");

	// ram bit decode
	bit_ram_a: assert property (@(posedge ref_clk) disable iff (rst)
		!bit_addr[7] |=> bit_byte_addr == `BIT_RAM_BASE + {4'h0, $past(bit_addr[6:3])} &&
		bit_index == $past(bit_addr[2:0]))
		else $error("ram bit decode wrong");

	// register bit decode
	bit_sfr_a: assert property (@(posedge ref_clk) disable iff (rst)
		bit_addr[7] |=> bit_byte_addr[2:0] == 3'h0 && bit_is_sfr)
		else $error("sfr bit decode wrong");
endmodule
`default_nettype wire

// File: core_exec_model.sv
// execution unit model driving register, stack and pointer move requests
`timescale 1ns/1ps
`default_nettype none

module core_exec_model
(
	// clock
	input  wire logic            ref_clk,
	// requests toward the block
	output logic                 sfr_wr,
	output logic                 sfr_rd,
	output logic                 sfr_direct,
	output logic          [7:0]  sfr_addr,
	output logic          [7:0]  sfr_wdata,
	output var core_ptr_pkg::stack_op_e stack_op,
	output logic                 external_data_move,
	output logic                 code_table_read,
	output logic                 muldiv_wr,
	output logic          [7:0]  muldiv_b
);
	// idle values; every request starts at a falling edge and lasts one cycle
	initial
	begin
		{sfr_wr, sfr_rd, sfr_direct, external_data_move, code_table_read, muldiv_wr} = 6'h00;
		{sfr_addr, sfr_wdata, muldiv_b} = 24'h000000;
		stack_op = core_ptr_pkg::STACK_NONE;
	end

	// register access; address and data are scrambled after release so stale values never help
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic dir);
		@(negedge ref_clk);
		{sfr_wr, sfr_rd} = {w, !w};
		{sfr_addr, sfr_wdata, sfr_direct} = {a, d, dir};
		@(negedge ref_clk);
		{sfr_wr, sfr_rd} = 2'h0;
		{sfr_addr, sfr_wdata, sfr_direct} = {~a, ~d, !dir};
	endtask

	// one stack byte
	task automatic stack_byte(input core_ptr_pkg::stack_op_e op);
		@(negedge ref_clk);
		stack_op = op;
		@(negedge ref_clk);
		stack_op = core_ptr_pkg::STACK_NONE;
	endtask

	// pointer move: data move, or code table read when code is set
	task automatic mv(input logic code);
		@(negedge ref_clk);
		{external_data_move, code_table_read} = {!code, code};
		@(negedge ref_clk);
		{external_data_move, code_table_read} = 2'h0;
	endtask

	// multiply or divide result into the b register
	task automatic md(input logic [7:0] b);
		@(negedge ref_clk);
		{muldiv_wr, muldiv_b} = {1'b1, b};
		@(negedge ref_clk);
		{muldiv_wr, muldiv_b} = {1'b0, ~b};
	endtask
endmodule

`default_nettype wire

// File: tb_core_pointer_bit_addressing.sv
// self-checking bench for stack, data pointers, b register and bit decode
`timescale 1ns/1ps
`default_nettype none
`include "core_ptr_defines.svh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %0t got %h expected %h", $time, g, e); end end

module tb_core_pointer_bit_addressing;
	// clock, reset and ports
	logic                  ref_clk = 1'b0;
	logic                  rst;
	logic                  sfr_wr, sfr_rd, sfr_direct, sfr_hit, bit_is_sfr;
	logic                  edm, ctr, muldiv_wr;
	logic           [7:0]  sfr_addr, sfr_wdata, sfr_rdata, stack_addr, muldiv_b, b_value;
	logic           [7:0]  bit_addr, bit_byte_addr, r, corners [4];
	logic           [2:0]  bit_index;
	logic           [15:0] move_addr, p0, p1;
	core_ptr_pkg::stack_op_e stack_op;
	int                    bad_count = 0;
	int                    samples_checked = 0;
	integer                seed = 65;

	always #5 ref_clk = ~ref_clk;

	core_exec_model cpu (.ref_clk(ref_clk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_direct(sfr_direct), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.stack_op(stack_op), .external_data_move(edm), .code_table_read(ctr),
		.muldiv_wr(muldiv_wr), .muldiv_b(muldiv_b));

	core_ptr_regs DUT (.ref_clk(ref_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_direct(sfr_direct), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .stack_op(stack_op),
		.stack_addr(stack_addr),
		.external_data_move(edm), .code_table_read(ctr), .move_addr(move_addr),
		.muldiv_wr(muldiv_wr), .muldiv_b(muldiv_b), .b_value(b_value), .bit_addr(bit_addr),
		.bit_byte_addr(bit_byte_addr), .bit_index(bit_index), .bit_is_sfr(bit_is_sfr));

	// expected decode: {byte, bit, register space}
	function automatic logic [11:0] bit_exp(input logic [7:0] a);
		if (a[7])
			return {a & 8'hF8, a[2:0], 1'b1};
		return {`BIT_RAM_BASE + {4'h0, a[6:3]}, a[2:0], 1'b0};
	endfunction

	// direct register write and checked read
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu.acc(1'b1, a, d, 1'b1);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
		cpu.acc(1'b0, a, 8'h00, 1'b1);
		`CHK(sfr_rdata, e)
		`CHK(sfr_hit, h)
	endtask

	task automatic close_out();
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog well beyond the roughly 130 cycles the sequence needs
	initial
	begin
		#100000;
		bad_count++;
		close_out();
	end

	initial
	begin
		rst = 1'b1;
		bit_addr = 8'h00;
		corners = '{8'h00, 8'h7F, 8'h80, 8'hF7};
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		rdc(`SFR_STACK_ADDR, `STACK_RESET, 1'b1);
		rdc(`SFR_SEL_ADDR, `SEL_RESET, 1'b1);
		rdc(`SFR_CTL_ADDR, 8'h00, 1'b1);
		rdc(8'h86, 8'h00, 1'b0);
		// a direct read below the register space never hits here
		rdc(8'h20, 8'h00, 1'b0);
		// stack order and the wrap at the top of the eight-bit range
		cpu.stack_byte(core_ptr_pkg::STACK_PUSH);
		`CHK(stack_addr, 8'h08)
		cpu.stack_byte(core_ptr_pkg::STACK_POP);
		`CHK(stack_addr, 8'h08)
		wr(`SFR_STACK_ADDR, 8'hFF);
		cpu.stack_byte(core_ptr_pkg::STACK_PUSH);
		`CHK(stack_addr, 8'h00)
		rdc(`SFR_STACK_ADDR, 8'h00, 1'b1);
		// select bit, and indirect accesses never reach registers
		wr(`SFR_SEL_ADDR, 8'hFF);
		rdc(`SFR_SEL_ADDR, 8'h01, 1'b1);
		cpu.acc(1'b1, `SFR_SEL_ADDR, 8'h00, 1'b0);
		rdc(`SFR_SEL_ADDR, 8'h01, 1'b1);
		cpu.acc(1'b0, `SFR_SEL_ADDR, 8'h00, 1'b0);
		`CHK({sfr_hit, sfr_rdata}, 9'h000)
		// per-pointer control copies: ptr one gets next=1, step 2, decrement, enable
		wr(`SFR_CTL_ADDR, 8'hFF);
		rdc(`SFR_CTL_ADDR, 8'h0F, 1'b1);
		wr(`SFR_SEL_ADDR, 8'h00);
		wr(`SFR_CTL_ADDR, 8'h01);
		rdc(`SFR_CTL_ADDR, 8'h01, 1'b1);
		p0 = 16'($random(seed));
		p1 = {15'h0000, 1'b1};
		wr(`SFR_PZL_ADDR, p0[7:0]);
		wr(`SFR_PZH_ADDR, p0[15:8]);
		wr(`SFR_POL_ADDR, p1[7:0]);
		wr(`SFR_POH_ADDR, p1[15:8]);
		rdc(`SFR_PZH_ADDR, p0[15:8], 1'b1);
		// moves through pointer zero, then auto switch to pointer one
		cpu.mv(1'b0);
		`CHK(move_addr, p0)
		p0 = p0 + 16'h0001;
		rdc(`SFR_PZL_ADDR, p0[7:0], 1'b1);
		rdc(`SFR_SEL_ADDR, 8'h00, 1'b1);
		wr(`SFR_CTL_ADDR, 8'h09);
		cpu.mv(1'b0);
		`CHK(move_addr, p0)
		rdc(`SFR_SEL_ADDR, 8'h01, 1'b1);
		cpu.mv(1'b0);
		`CHK(move_addr, p1)
		p1 = p1 - 16'h0002;
		rdc(`SFR_POL_ADDR, p1[7:0], 1'b1);
		rdc(`SFR_POH_ADDR, p1[15:8], 1'b1);
		cpu.mv(1'b1);
		`CHK(move_addr, p1)
		// b register by software and by multiply result
		r = 8'($random(seed));
		wr(`SFR_B_ADDR, r);
		rdc(`SFR_B_ADDR, r, 1'b1);
		cpu.md(~r);
		`CHK(b_value, ~r)
		// bit decode: corners then random addresses
		for (int i = 0; i < 44; i++)
		begin
			bit_addr = (i < 4) ? corners[i] : 8'($random(seed));
			@(negedge ref_clk);
			`CHK({bit_byte_addr, bit_index, bit_is_sfr}, bit_exp(bit_addr))
		end
		// reset again in mid-run
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		rdc(`SFR_STACK_ADDR, `STACK_RESET, 1'b1);
		close_out();
	end
endmodule

`default_nettype wire
